// File: include/dpm_defines.svh
`ifndef DPM_DEFINES_SVH
`define DPM_DEFINES_SVH

// register map, per-section offsets inside a stride of 0x20
`define DPM_SEC_CFG 5'h00
`define DPM_SEC_START_ADDR 5'h04
`define DPM_SEC_START_VAL 5'h08
`define DPM_SEC_END_ADDR 5'h0c
`define DPM_SEC_END_VAL 5'h10
`define DPM_SEC_CNT 5'h14
`define DPM_SEC_STATUS 5'h18
`define DPM_GLOBAL_CTRL 8'h40
`define DPM_GLOBAL_CNT_HI 8'h44

// field positions and widths
`define DPM_SEC_SEL_BIT 5
`define DPM_GLOBAL_BIT 6
`define DPM_HIGH_BIT 7
`define DPM_CFG_W 9
`define DPM_MODE_W 2
`define DPM_CLEAR_BIT 0

// counter limits per configuration
`define DPM_MAX_DUAL 64'h0000_0000_ffff_ffff
`define DPM_MAX_WIDE 64'hffff_ffff_ffff_ffff
`define DPM_MAX_REDUCED 64'h0000_0000_00ff_ffff

// reset values
`define DPM_CFG_RST 9'h000
`define DPM_MODE_RST 2'h0
`define DPM_WORD_RST 32'h0000_0000

`endif

// File: include/dpm_pkg.sv
package dpm_pkg;

  typedef enum logic [3:0] {
    DPM_ITEM_ELAPSED = 4'h0,
    DPM_ITEM_SUP_CYC = 4'h1,
    DPM_ITEM_HANDLE_CYC = 4'h2,
    DPM_ITEM_EXC_CYC = 4'h3,
    DPM_ITEM_IRQ_CYC = 4'h4,
    DPM_ITEM_INST_CNT = 4'h5,
    DPM_ITEM_EVENT_CNT = 4'h6,
    DPM_ITEM_EXC_CNT = 4'h7,
    DPM_ITEM_IRQ_CNT = 4'h8
  } dpm_item_t;

  typedef enum logic [1:0] {
    DPM_MODE_DUAL = 2'h0,
    DPM_MODE_WIDE = 2'h1,
    DPM_MODE_REDUCED = 2'h2
  } dpm_mode_t;

  // event and status signals from the core, all on the core clock
  typedef struct packed {
    logic running;
    logic inst_done;
    logic [31:0] inst_addr;
    logic acc_valid;
    logic [31:0] acc_addr;
    logic [31:0] acc_data;
    logic supervisor;
    logic exc_busy;
    logic irq_busy;
    logic exc_event;
    logic irq_accept;
  } dpm_core_t;

  typedef struct packed {
    logic end_access;
    logic start_access;
    logic end_arm;
    logic start_arm;
    logic one_shot;
    dpm_item_t item;
  } dpm_cfg_t;

  typedef struct packed {
    dpm_cfg_t cfg;
    logic [31:0] start_addr;
    logic [31:0] start_val;
    logic [31:0] end_addr;
    logic [31:0] end_val;
    logic [63:0] cnt;
    logic open;
    logic ovf;
    logic valid;
    logic done;
    logic susp;
    logic passed;
  } dpm_sec_t;

  typedef struct packed {
    dpm_sec_t [1:0] sec;
    dpm_mode_t mode;
    logic run_q;
    logic [31:0] rdata;
  } dpm_state_t;

endpackage : dpm_pkg

// File: sim/debug_section_perf_meter_tb_top.sv
module debug_section_perf_meter_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk;
  logic rst_n;
  dpm_pkg::dpm_core_t core;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_we;
  logic reg_re;
  logic [31:0] reg_rdata;
  logic [1:0] sec_open;
  logic [1:0] sec_ovf;
  logic [31:0] d;
  int error_cnt;
  int tests_run;
  localparam logic [31:0] ITEM_EXP [9] = '{32'ha, 32'h3, 32'h5, 32'h2, 32'h3, 32'h2,
    32'h2, 32'h1, 32'h1};

  dpm_perf_meter uut (.ref_clk(ref_clk), .rst_n(rst_n), .core(core), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .sec_open(sec_open), .sec_ovf(sec_ovf));
  dpm_core_model u_core (.ref_clk(ref_clk), .core(core));

  always #25 ref_clk = ~ref_clk;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk_reg
  task automatic chk_pin(input string n, input logic [1:0] e, input logic [1:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask : chk_pin
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_re <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] v;
    rd(a, v);
    chk_reg(n, e, v);
  endtask : rdc
  // waits for the core model to play out its queue, bounded
  task automatic settle();
    int k;
    k = 0;
    while (u_core.q.size() > 0 && k < 300) begin
      @(posedge ref_clk);
      k++;
    end
    if (k >= 300) begin
      error_cnt++;
      print_verdict();
    end
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : settle
  // one window: 3 supervisor, 2 exception, 3 interrupt cycles, then 2 instructions
  task automatic win();
    u_core.exec(32'h100);
    u_core.busy(3, 0);
    u_core.busy(2, 1);
    u_core.busy(3, 2);
    u_core.exec(32'h50);
    u_core.exec(32'h200);
  endtask : win

  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_we = 1'b0;
    reg_re = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    rdc(8'h00, 32'h0, "cfg reset");
    rdc(8'h18, 32'h0, "status reset");
    wr(8'h80, 32'hffff_ffff);
    wr(8'h03, 32'hffff_ffff);
    rdc(8'h80, 32'h0, "unmapped");
    rdc(8'h00, 32'h0, "cfg kept");
    rdc(8'h03, 32'h0, "misaligned");
    wr(8'h08, 32'ha5c3_3c5a);
    wr(8'h10, 32'h5a3c_c3a5);
    rdc(8'h08, 32'ha5c3_3c5a, "start value");
    rdc(8'h10, 32'h5a3c_c3a5, "end value");
    wr(8'h04, 32'h100);
    wr(8'h0c, 32'h200);
    for (int i = 0; i < 9; i++) begin
      wr(8'h00, 32'h60 + 32'(i));
      win();
      settle();
      rdc(8'h14, ITEM_EXP[i], "item count");
      rdc(8'h18, 32'h24, "item status");
      wr(8'h18, 32'h1);
    end
    wr(8'h00, 32'h60);
    win();
    win();
    settle();
    rdc(8'h14, 32'h14, "cycle total");
    wr(8'h18, 32'h1);
    wr(8'h00, 32'h68);
    win();
    win();
    settle();
    rdc(8'h14, 32'h2, "pass count");
    wr(8'h18, 32'h1);
    wr(8'h00, 32'h67);
    u_core.exec(32'h100);
    u_core.idle(2);
    u_core.exec(32'h200);
    settle();
    rdc(8'h18, 32'h60, "no result");
    wr(8'h18, 32'h1);
    wr(8'h00, 32'h70);
    win();
    win();
    settle();
    rdc(8'h14, 32'ha, "one shot count");
    rdc(8'h18, 32'h2c, "one shot status");
    wr(8'h18, 32'h1);
    u_core.exec(32'h100);
    u_core.idle(2);
    u_core.exec(32'h100);
    u_core.idle(2);
    settle();
    chk_pin("open", 2'h0, sec_open);
    rd(8'h18, d);
    chk_reg("suspended", 32'h1, {31'h0, d[4]});
    wr(8'h18, 32'h1);
    wr(8'h04, 32'h1404);
    wr(8'h08, 32'hb);
    wr(8'h00, 32'he0);
    u_core.access(32'h1404, 32'h5);
    u_core.access(32'h1400, 32'hb);
    u_core.idle(2);
    u_core.exec(32'h200);
    settle();
    rdc(8'h14, 32'h0, "access miss");
    u_core.access(32'h1404, 32'hb);
    u_core.idle(3);
    u_core.exec(32'h200);
    settle();
    rdc(8'h14, 32'h4, "access hit");
    wr(8'h18, 32'h1);
    wr(8'h04, 32'h100);
    wr(8'h00, 32'h40);
    u_core.run(1'b1);
    u_core.idle(3);
    u_core.exec(32'h200);
    settle();
    rdc(8'h14, 32'h4, "run start");
    wr(8'h18, 32'h1);
    wr(8'h00, 32'h20);
    u_core.exec(32'h100);
    u_core.idle(2);
    settle();
    chk_pin("open", 2'h1, sec_open);
    u_core.run(1'b0);
    settle();
    chk_pin("open", 2'h0, sec_open);
    wr(8'h18, 32'h1);
    wr(8'h0c, 32'h100);
    wr(8'h00, 32'h60);
    u_core.exec(32'h100);
    settle();
    chk_pin("open", 2'h0, sec_open);
    rdc(8'h14, 32'h0, "same instr");
    wr(8'h0c, 32'h200);
    wr(8'h40, 32'h2);
    wr(8'h00, 32'h65);
    win();
    settle();
    rdc(8'h14, 32'ha, "reduced");
    wr(8'h40, 32'h1);
    wr(8'h24, 32'h100);
    wr(8'h2c, 32'h200);
    wr(8'h20, 32'h60);
    win();
    settle();
    rdc(8'h34, 32'h0, "sec1 off");
    rdc(8'h44, 32'h0, "high word");
    wr(8'h40, 32'h0);
    win();
    settle();
    rdc(8'h34, 32'ha, "sec1 dual");
    chk_pin("ovf", 2'h0, sec_ovf);
    print_verdict();
  end
endmodule : debug_section_perf_meter_tb_top

// File: sim/dpm_core_model.sv
module dpm_core_model (
  // clock
  input wire logic ref_clk,
  // core activity toward the meter
  output dpm_pkg::dpm_core_t core
);
  timeunit 1ns;
  timeprecision 1ns;
  dpm_pkg::dpm_core_t q[$];
  dpm_pkg::dpm_core_t last;
  logic run_lvl;
  initial begin
    last = '0;
    run_lvl = 1'b0;
  end
  // idle bus lines show the inverse of their last value
  function automatic dpm_pkg::dpm_core_t base();
    dpm_pkg::dpm_core_t t;
    t = '0;
    t.running = run_lvl;
    t.inst_addr = ~last.inst_addr;
    t.acc_addr = ~last.acc_addr;
    t.acc_data = ~last.acc_data;
    return t;
  endfunction : base
  task automatic push(input dpm_pkg::dpm_core_t t);
    q.push_back(t);
    last = t;
  endtask : push
  task automatic exec(input logic [31:0] a);
    dpm_pkg::dpm_core_t t;
    t = base();
    t.inst_done = 1'b1;
    t.inst_addr = a;
    push(t);
  endtask : exec
  task automatic access(input logic [31:0] a, input logic [31:0] d);
    dpm_pkg::dpm_core_t t;
    t = base();
    t.acc_valid = 1'b1;
    t.acc_addr = a;
    t.acc_data = d;
    push(t);
  endtask : access
  task automatic idle(input int n);
    repeat (n) push(base());
  endtask : idle
  task automatic run(input logic v);
    run_lvl = v;
    push(base());
  endtask : run
  // kind 0 supervisor, 1 exception, 2 interrupt; the event pulses on the first cycle
  task automatic busy(input int n, input int k);
    dpm_pkg::dpm_core_t t;
    for (int i = 0; i < n; i++) begin
      t = base();
      t.supervisor = (k == 0);
      t.exc_busy = (k == 1);
      t.irq_busy = (k == 2);
      t.exc_event = (k == 1) && (i == 0);
      t.irq_accept = (k == 2) && (i == 0);
      push(t);
    end
  endtask : busy
  always @(posedge ref_clk) begin
    if (q.size() > 0) begin
      core <= q.pop_front();
    end else begin
      core <= base();
    end
  end
endmodule : dpm_core_model

// File: verilog/dpm_event_match.sv
`include "dpm_defines.svh"

module dpm_event_match (
  // event setting
  input wire logic arm,
  input wire logic access,
  input wire logic [31:0] addr,
  input wire logic [31:0] value,
  // core activity
  input wire dpm_pkg::dpm_core_t core,
  // match
  output logic hit
);
  logic exec_hit;
  logic acc_hit;

  // execution event fires when the instruction at the address completes
  assign exec_hit = core.inst_done && (core.inst_addr == addr);
  // access event needs both the location and the compare value
  assign acc_hit = core.acc_valid && (core.acc_addr == addr) && (core.acc_data == value);
  assign hit = arm && (access ? acc_hit : exec_hit);
endmodule : dpm_event_match

// File: verilog/dpm_perf_meter.sv
// Local design decisions: the register offsets and strobed register access.
`include "dpm_defines.svh"

// Functional notes
// - start only: halt closes the window
// - end only: run start opens window
// - armed instruction completion opens or closes
// - access event needs matching compare value
// - elapsed item counts every open cycle
// - supervisor item counts supervisor open cycles
// - handling item counts interrupt or exception cycles
// - exception cycle item excludes interrupt handling
// - interrupt cycle item excludes exceptions
// - instruction item counts completed instructions
// - event item counts interrupts and exceptions
// - exception count ignores interrupts
// - interrupt count ignores exceptions
// - cycle items accumulate over all passes
// - count items report pass totals
// - no average, maximum or minimum kept
// - one-shot stops after one window
// - one-shot second start suspends measurement
// - count item with no events flags invalid
// - reduced variant offers elapsed item only
// - same-instruction start/end closes or ignores
// - full variant: two 32-bit or one 64-bit
// - reduced variant: one 24-bit counter
// - counter overflow detected and reported
module dpm_perf_meter (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // core events
  input wire dpm_pkg::dpm_core_t core,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  // section status
  output logic [1:0] sec_open,
  output logic [1:0] sec_ovf
);
  dpm_pkg::dpm_state_t st;
  dpm_pkg::dpm_state_t next_st;
  logic rst_sync_n;
  logic [1:0] start_hit;
  logic [1:0] end_hit;
  logic [1:0] sec_on;
  logic [1:0] clr;
  logic [1:0] cnt_item;
  logic run_rise;
  logic run_fall;
  logic [63:0] cnt_max;
  dpm_pkg::dpm_item_t item [1:0];
  logic [1:0] amt [1:0];

  dpm_rst_sync u_rst_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .rst_sync_n(rst_sync_n)
  );

  for (genvar g = 0; g < 2; g++) begin : g_sec
    dpm_event_match u_start (
      .arm(st.sec[g].cfg.start_arm),
      .access(st.sec[g].cfg.start_access),
      .addr(st.sec[g].start_addr),
      .value(st.sec[g].start_val),
      .core(core),
      .hit(start_hit[g])
    );
    dpm_event_match u_end (
      .arm(st.sec[g].cfg.end_arm),
      .access(st.sec[g].cfg.end_access),
      .addr(st.sec[g].end_addr),
      .value(st.sec[g].end_val),
      .core(core),
      .hit(end_hit[g])
    );
    // section 1 exists only with the dual 32-bit counters
    assign sec_on[g] = (g == 0) || (st.mode == dpm_pkg::DPM_MODE_DUAL);
    // status write with the clear bit drops that section's results
    // offsets at and above 0x80 are unmapped
    assign clr[g] = reg_we && !reg_addr[`DPM_GLOBAL_BIT] && !reg_addr[`DPM_HIGH_BIT]
      && (reg_addr[`DPM_SEC_SEL_BIT] == 1'(g)) && (reg_addr[4:0] == `DPM_SEC_STATUS)
      && reg_wdata[`DPM_CLEAR_BIT];
    // reduced variant forces the elapsed item
    assign item[g] = (st.mode == dpm_pkg::DPM_MODE_REDUCED) ? dpm_pkg::DPM_ITEM_ELAPSED
      : st.sec[g].cfg.item;
    assign cnt_item[g] = (item[g] == dpm_pkg::DPM_ITEM_INST_CNT)
      || (item[g] == dpm_pkg::DPM_ITEM_EVENT_CNT) || (item[g] == dpm_pkg::DPM_ITEM_EXC_CNT)
      || (item[g] == dpm_pkg::DPM_ITEM_IRQ_CNT);
  end

  assign run_rise = core.running && !st.run_q;
  assign run_fall = !core.running && st.run_q;

  always_comb begin
    unique case (st.mode)
      dpm_pkg::DPM_MODE_WIDE: cnt_max = `DPM_MAX_WIDE;
      dpm_pkg::DPM_MODE_REDUCED: cnt_max = `DPM_MAX_REDUCED;
      default: cnt_max = `DPM_MAX_DUAL;
    endcase
  end

  // increment amount per section for the selected item
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      unique case (item[i])
        dpm_pkg::DPM_ITEM_ELAPSED: amt[i] = 2'h1;
        dpm_pkg::DPM_ITEM_SUP_CYC: amt[i] = {1'b0, core.supervisor};
        dpm_pkg::DPM_ITEM_HANDLE_CYC: amt[i] = {1'b0, core.exc_busy || core.irq_busy};
        dpm_pkg::DPM_ITEM_EXC_CYC: amt[i] = {1'b0, core.exc_busy};
        dpm_pkg::DPM_ITEM_IRQ_CYC: amt[i] = {1'b0, core.irq_busy};
        dpm_pkg::DPM_ITEM_INST_CNT: amt[i] = {1'b0, core.inst_done};
        dpm_pkg::DPM_ITEM_EVENT_CNT: amt[i] = {1'b0, core.exc_event}
          + {1'b0, core.irq_accept};
        dpm_pkg::DPM_ITEM_EXC_CNT: amt[i] = {1'b0, core.exc_event};
        dpm_pkg::DPM_ITEM_IRQ_CNT: amt[i] = {1'b0, core.irq_accept};
        default: amt[i] = 2'h0;
      endcase
    end
  end

  always_comb begin
    logic [64:0] sum;
    logic close;
    sum = 65'h0;
    close = 1'b0;
    next_st = st;
    next_st.run_q = core.running;
    next_st.rdata = `DPM_WORD_RST;

    // register writes
    if (reg_we && reg_addr == `DPM_GLOBAL_CTRL) begin
      next_st.mode = dpm_pkg::dpm_mode_t'(reg_wdata[`DPM_MODE_W-1:0]);
    end
    for (int i = 0; i < 2; i++) begin
      if (reg_we && !reg_addr[`DPM_GLOBAL_BIT] && !reg_addr[`DPM_HIGH_BIT]
          && reg_addr[`DPM_SEC_SEL_BIT] == i[0]) begin
        unique case (reg_addr[4:0])
          `DPM_SEC_CFG: next_st.sec[i].cfg = dpm_pkg::dpm_cfg_t'(reg_wdata[`DPM_CFG_W-1:0]);
          `DPM_SEC_START_ADDR: next_st.sec[i].start_addr = reg_wdata;
          `DPM_SEC_START_VAL: next_st.sec[i].start_val = reg_wdata;
          `DPM_SEC_END_ADDR: next_st.sec[i].end_addr = reg_wdata;
          `DPM_SEC_END_VAL: next_st.sec[i].end_val = reg_wdata;
          default: ;
        endcase
      end
      // clear first so that events in the same cycle still land
      if (clr[i]) begin
        next_st.sec[i].cnt = 64'h0;
        next_st.sec[i].open = 1'b0;
        next_st.sec[i].ovf = 1'b0;
        next_st.sec[i].valid = 1'b0;
        next_st.sec[i].done = 1'b0;
        next_st.sec[i].susp = 1'b0;
        next_st.sec[i].passed = 1'b0;
      end

      // counting uses the window as it stood this cycle; totals only, no per-pass stats
      if (sec_on[i] && st.sec[i].open && amt[i] != 2'h0) begin
        sum = {1'b0, next_st.sec[i].cnt} + {63'h0, amt[i]};
        next_st.sec[i].valid = 1'b1;
        if (sum > {1'b0, cnt_max}) begin
          next_st.sec[i].ovf = 1'b1;
          sum = sum - {1'b0, cnt_max} - 65'h1;
        end
        next_st.sec[i].cnt = sum[63:0];
      end

      // window control
      close = 1'b0;
      if (!sec_on[i]) begin
        next_st.sec[i].open = 1'b0;
      end else if (end_hit[i]) begin
        // end wins on a shared instruction: close if open, otherwise nothing
        close = st.sec[i].open;
      end else if (start_hit[i]) begin
        if (st.sec[i].open && st.sec[i].cfg.one_shot) begin
          next_st.sec[i].open = 1'b0;
          next_st.sec[i].susp = 1'b1;
        end else if (!next_st.sec[i].done && !next_st.sec[i].susp) begin
          next_st.sec[i].open = 1'b1;
        end
      end else if (run_rise && st.sec[i].cfg.end_arm && !st.sec[i].cfg.start_arm
          && !next_st.sec[i].done && !next_st.sec[i].susp) begin
        next_st.sec[i].open = 1'b1;
      end else if (run_fall && st.sec[i].cfg.start_arm && !st.sec[i].cfg.end_arm) begin
        close = st.sec[i].open;
      end
      if (close) begin
        next_st.sec[i].open = 1'b0;
        next_st.sec[i].passed = 1'b1;
        next_st.sec[i].done = st.sec[i].cfg.one_shot;
      end
    end

    // register reads, data valid in the following cycle
    if (reg_re) begin
      if (reg_addr == `DPM_GLOBAL_CTRL) begin
        next_st.rdata = {30'h0, st.mode};
      end else if (reg_addr == `DPM_GLOBAL_CNT_HI) begin
        next_st.rdata = st.sec[0].cnt[63:32];
      end else if (!reg_addr[`DPM_GLOBAL_BIT] && !reg_addr[`DPM_HIGH_BIT]) begin
        for (int i = 0; i < 2; i++) begin
          if (reg_addr[`DPM_SEC_SEL_BIT] == i[0]) begin
            unique case (reg_addr[4:0])
              `DPM_SEC_CFG: next_st.rdata = {23'h0, st.sec[i].cfg};
              `DPM_SEC_START_ADDR: next_st.rdata = st.sec[i].start_addr;
              `DPM_SEC_START_VAL: next_st.rdata = st.sec[i].start_val;
              `DPM_SEC_END_ADDR: next_st.rdata = st.sec[i].end_addr;
              `DPM_SEC_END_VAL: next_st.rdata = st.sec[i].end_val;
              `DPM_SEC_CNT: next_st.rdata = st.sec[i].cnt[31:0];
              // bit 6 marks a finished count pass that never saw its event
              `DPM_SEC_STATUS: next_st.rdata = {25'h0,
                st.sec[i].passed && cnt_item[i] && !st.sec[i].valid,
                st.sec[i].passed, st.sec[i].susp, st.sec[i].done,
                st.sec[i].valid, st.sec[i].ovf, st.sec[i].open};
              default: next_st.rdata = `DPM_WORD_RST;
            endcase
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign sec_open = {st.sec[1].open, st.sec[0].open};
  assign sec_ovf = {st.sec[1].ovf, st.sec[0].ovf};

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_sync_n);

  sequence s_start_only;
    start_hit[0] && !end_hit[0] && !st.sec[0].open && !st.sec[0].done && !st.sec[0].susp;
  endsequence

  sequence s_open_now;
    st.sec[0].open && st.sec[0].cfg.one_shot;
  endsequence

  open_on_start_a: assert property (s_start_only ##0 !clr[0] |=> st.sec[0].open)
    else $error("window did not open on start event");

  close_on_end_a: assert property (end_hit[0] && st.sec[0].open |=> !st.sec[0].open)
    else $error("window did not close on end event");

  shared_inst_a: assert property (start_hit[0] && end_hit[0] && !st.sec[0].open
    |=> !st.sec[0].open)
    else $error("same instruction start and end opened a window");

  halt_close_a: assert property (run_fall && st.sec[0].open && st.sec[0].cfg.start_arm
    && !st.sec[0].cfg.end_arm && !end_hit[0] && !start_hit[0] |=> !st.sec[0].open)
    else $error("halt did not close start-only window");

  run_open_a: assert property (run_rise && !st.sec[0].open && st.sec[0].cfg.end_arm
    && !st.sec[0].cfg.start_arm && !st.sec[0].done && !st.sec[0].susp && !end_hit[0]
    && !clr[0] |=> st.sec[0].open)
    else $error("run start did not open end-only window");

  second_start_a: assert property (s_open_now ##0 (start_hit[0] && !end_hit[0])
    |=> st.sec[0].susp && !st.sec[0].open ##1 !st.sec[0].open)
    else $error("second start in one-shot did not suspend");

  oneshot_stop_a: assert property (st.sec[0].done && !clr[0] |=> !st.sec[0].open)
    else $error("one-shot section reopened");

  elapsed_inc_a: assert property (st.sec[0].open && item[0] == dpm_pkg::DPM_ITEM_ELAPSED
    && st.sec[0].cnt < cnt_max && !clr[0] && !$changed(st.mode)
    |=> st.sec[0].cnt == $past(st.sec[0].cnt) + 64'h1)
    else $error("elapsed count did not advance by one");

  ovf_hold_a: assert property (st.sec[0].ovf && !clr[0] |=> st.sec[0].ovf)
    else $error("overflow flag dropped without clear");

  reduced_only_a: assert property (st.mode == dpm_pkg::DPM_MODE_REDUCED && $stable(st.mode)
    |-> item[0] == dpm_pkg::DPM_ITEM_ELAPSED && !st.sec[1].open)
    else $error("reduced variant used another item or section");

  read_latency_a: assert property (reg_re && reg_addr == `DPM_GLOBAL_CTRL
    |=> reg_rdata == {30'h0, $past(st.mode)})
    else $error("control read data wrong");

  // open window, no clear, and room left below the limit for one more step
  sequence s_cnt_live;
    st.sec[0].open && !clr[0] && st.sec[0].cnt < cnt_max - 64'h1;
  endsequence

  sup_cyc_a: assert property (s_cnt_live ##0
    (item[0] == dpm_pkg::DPM_ITEM_SUP_CYC && core.supervisor)
    |=> st.sec[0].cnt == $past(st.sec[0].cnt) + 64'h1)
    else $error("supervisor cycle not counted");

  user_idle_a: assert property (s_cnt_live ##0
    (item[0] == dpm_pkg::DPM_ITEM_SUP_CYC && !core.supervisor) |=> $stable(st.sec[0].cnt))
    else $error("user mode cycle counted as supervisor");

  handle_cyc_a: assert property (s_cnt_live ##0
    (item[0] == dpm_pkg::DPM_ITEM_HANDLE_CYC && (core.exc_busy || core.irq_busy))
    |=> st.sec[0].cnt == $past(st.sec[0].cnt) + 64'h1)
    else $error("handling cycle not counted");

  exc_cyc_a: assert property (s_cnt_live ##0
    (item[0] == dpm_pkg::DPM_ITEM_EXC_CYC && core.irq_busy && !core.exc_busy)
    |=> $stable(st.sec[0].cnt))
    else $error("interrupt cycle counted as exception");

  irq_cyc_a: assert property (s_cnt_live ##0
    (item[0] == dpm_pkg::DPM_ITEM_IRQ_CYC && core.exc_busy && !core.irq_busy)
    |=> $stable(st.sec[0].cnt))
    else $error("exception cycle counted as interrupt");

  inst_cnt_a: assert property (s_cnt_live ##0
    (item[0] == dpm_pkg::DPM_ITEM_INST_CNT && core.inst_done)
    |=> st.sec[0].cnt == $past(st.sec[0].cnt) + 64'h1)
    else $error("completed instruction not counted");

  event_cnt_a: assert property (s_cnt_live ##0
    (item[0] == dpm_pkg::DPM_ITEM_EVENT_CNT && (core.exc_event != core.irq_accept))
    |=> st.sec[0].cnt == $past(st.sec[0].cnt) + 64'h1)
    else $error("interrupt or exception not counted");

  exc_cnt_a: assert property (s_cnt_live ##0
    (item[0] == dpm_pkg::DPM_ITEM_EXC_CNT && core.irq_accept && !core.exc_event)
    |=> $stable(st.sec[0].cnt))
    else $error("interrupt counted as exception");

  irq_cnt_a: assert property (s_cnt_live ##0
    (item[0] == dpm_pkg::DPM_ITEM_IRQ_CNT && core.exc_event && !core.irq_accept)
    |=> $stable(st.sec[0].cnt))
    else $error("exception counted as interrupt");

  closed_hold_a: assert property (!st.sec[0].open && !clr[0]
    |=> $stable(st.sec[0].cnt) && $stable(st.sec[0].valid))
    else $error("count or valid moved with window closed");

  ovf_wrap_a: assert property (st.sec[0].open && !clr[0]
    && item[0] == dpm_pkg::DPM_ITEM_ELAPSED && st.sec[0].cnt == cnt_max
    |=> st.sec[0].ovf && st.sec[0].cnt == 64'h0)
    else $error("counter limit passed without overflow");

  sec1_off_a: assert property (st.mode != dpm_pkg::DPM_MODE_DUAL && $stable(st.mode)
    |-> !st.sec[1].open)
    else $error("second section open outside dual mode");
endmodule : dpm_perf_meter

// File: verilog/dpm_rst_sync.sv
module dpm_rst_sync (
  // clock and raw reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // released reset
  output logic rst_sync_n
);
  logic [1:0] sync;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync <= 2'h0;
    end else begin
      sync <= {sync[0], 1'b1};
    end
  end

  assign rst_sync_n = sync[1];
endmodule : dpm_rst_sync
